// *** rtl/gate_supervisor.sv ***
// Fault latch and output enable supervisor for six gate driver channels.
`timescale 1ns/1ps
`include "gate_supervisor_regs.svh"

// Notes on behaviour
// R01: Any channel fault disables all channel enables.
// R02: Fault bit set only on faulting channel.
// R03: After fault, status shows all enables off.
// R04: Fault stays latched until reset request.
// R05: Host sends reset once, then clears it.
// R06: Reset clears faults and re-enables all channels.
// R07: Disabled channel holds both gate outputs low.
// R08: Channels 1-3 first group, 4-6 second.
// R09: Status shows enables exactly as host chose.
// R10: Indicator toggles on every command packet.
// R11: Fault still present at reset relatches.
module gate_supervisor
	import gate_supervisor_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] driver_fault,
	input wire logic [5:0] pwm_high_in,
	input wire logic [5:0] pwm_low_in,
	output logic [5:0] gate_high,
	output logic [5:0] gate_low,
	output logic [5:0] output_enable,
	output logic packet_indicator
);
	localparam int GROUP_SIZE = 3;

	function automatic logic addr_hit(input logic [3:0] a,
		input logic [3:0] off);
		addr_hit = (a[3:2] == off[3:2]);
	endfunction

	logic [5:0] fault_meta;
	logic [5:0] fault_sync;
	status_s state;
	status_s next_state;
	logic next_indicator;
	logic [15:0] packets;
	logic [15:0] next_packets;
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [3:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic wr_fire;
	logic cmd_write;
	command_s cmd;
	chan_t fault_now;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_meta <= 6'h00;
			fault_sync <= 6'h00;
		end else begin
			fault_meta <= driver_fault;
			fault_sync <= fault_meta;
		end
	end

	assign fault_now = fault_sync;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		wr_fire = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			wr_fire = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (addr_hit(aw_addr, `REG_COMMAND) ||
				addr_hit(aw_addr, `REG_STATUS) ||
				addr_hit(aw_addr, `REG_PACKETS)) ?
				`RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	assign cmd_write = wr_fire && addr_hit(aw_addr, `REG_COMMAND);

	// A command packet writes the enable mask and the one-shot reset.
	always_comb begin
		cmd.enable_req = w_data[`CMD_ENABLE_LSB +: `CHANNEL_COUNT];
		cmd.reset_req = w_data[`CMD_RESET_BIT] & w_strb[1];
		if (!w_strb[0]) begin
			cmd.enable_req = state.enable;
		end
	end

	// A fault arriving with a reset wins, so the latch cannot miss it.
	always_comb begin
		next_state = state;
		next_indicator = packet_indicator;
		next_packets = packets;
		if (cmd_write) begin
			next_indicator = !packet_indicator; // R10
			next_packets = packets + 16'h0001;
			if (cmd.reset_req) begin
				next_state.fault = 6'h00; // R06
				next_state.enable = `ENABLE_RESET; // R06
			end else if (state.fault == 6'h00) begin
				next_state.enable = cmd.enable_req; // R09 R08
			end
		end
		next_state.fault = next_state.fault | fault_now; // R02 R04 R11
		if (next_state.fault != 6'h00) begin
			next_state.enable = 6'h00; // R01 R03 R11
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state.fault <= 6'h00;
			state.enable <= `ENABLE_RESET;
			packet_indicator <= 1'b0;
			packets <= 16'h0000;
			output_enable <= `ENABLE_RESET;
		end else begin
			state <= next_state;
			packet_indicator <= next_indicator;
			packets <= next_packets;
			output_enable <= next_state.enable;
		end
	end

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `RESP_OKAY;
			next_rdata = 32'h00000000;
			if (addr_hit(s_axi_araddr, `REG_COMMAND)) begin
				next_rdata[`CMD_ENABLE_LSB +: `CHANNEL_COUNT] = state.enable;
			end else if (addr_hit(s_axi_araddr, `REG_STATUS)) begin
				next_rdata[`STAT_FAULT_LSB +: `CHANNEL_COUNT] = state.fault;
				next_rdata[`STAT_ENABLE_LSB +: `CHANNEL_COUNT] = state.enable;
				next_rdata[`STAT_INDICATOR_BIT] = packet_indicator;
			end else if (addr_hit(s_axi_araddr, `REG_PACKETS)) begin
				next_rdata[15:0] = packets;
			end else begin
				next_rresp = `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_awready <= !next_aw_held && !next_bvalid &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !next_w_held && !next_bvalid &&
				!(s_axi_wvalid && s_axi_wready);
			s_axi_arready <= !next_rvalid &&
				!(s_axi_arvalid && s_axi_arready);
		end
	end

	pwm_gate_mask u_mask (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(state.enable),
		.pwm_high_in(pwm_high_in),
		.pwm_low_in(pwm_low_in),
		.gate_high(gate_high),
		.gate_low(gate_low)
	);

	property p_fault_kills_all;
		@(posedge aclk) disable iff (!aresetn)
		(fault_sync != 6'h00) |=> (output_enable == 6'h00);
	endproperty
	a_fault_kills_all: assert property (p_fault_kills_all) // R01
		else $error("enables not cleared on fault");

	property p_fault_only_seen;
		@(posedge aclk) disable iff (!aresetn)
		(!cmd_write || !cmd.reset_req) |=>
		(state.fault == ($past(state.fault) | $past(fault_sync)));
	endproperty
	a_fault_only_seen: assert property (p_fault_only_seen) // R02
		else $error("fault bits differ from detected faults");

	property p_status_off;
		@(posedge aclk) disable iff (!aresetn)
		(state.fault != 6'h00) |-> (state.enable == 6'h00);
	endproperty
	a_status_off: assert property (p_status_off) // R03
		else $error("status shows enable while faulted");

	property p_latched;
		@(posedge aclk) disable iff (!aresetn)
		(state.fault != 6'h00 && !(cmd_write && cmd.reset_req)) |=>
		((state.fault & $past(state.fault)) == $past(state.fault));
	endproperty
	a_latched: assert property (p_latched) // R04
		else $error("fault cleared without reset");

	property p_reset_clears;
		@(posedge aclk) disable iff (!aresetn)
		(cmd_write && cmd.reset_req && fault_sync == 6'h00) |=>
		(state.fault == 6'h00 && state.enable == 6'h3F);
	endproperty
	a_reset_clears: assert property (p_reset_clears) // R06
		else $error("reset did not clear and re-enable");

	property p_enable_follows;
		@(posedge aclk) disable iff (!aresetn)
		(cmd_write && !cmd.reset_req && state.fault == 6'h00 &&
		fault_sync == 6'h00) |=> (state.enable == $past(cmd.enable_req));
	endproperty
	a_enable_follows: assert property (p_enable_follows) // R09
		else $error("enable differs from command");

	property p_toggle;
		@(posedge aclk) disable iff (!aresetn)
		cmd_write |=> (packet_indicator != $past(packet_indicator));
	endproperty
	a_toggle: assert property (p_toggle) // R10
		else $error("indicator did not toggle");

	property p_relatch;
		@(posedge aclk) disable iff (!aresetn)
		(cmd_write && cmd.reset_req && fault_sync != 6'h00) |=>
		(state.fault != 6'h00 && output_enable == 6'h00);
	endproperty
	a_relatch: assert property (p_relatch) // R11
		else $error("fault not relatched at reset");

	property p_group_split;
		@(posedge aclk) disable iff (!aresetn)
		(cmd_write && !cmd.reset_req && state.fault == 6'h00 &&
		fault_sync == 6'h00 && cmd.enable_req == 6'h38) |=>
		(output_enable[GROUP_SIZE-1:0] == 3'h0 &&
		output_enable[5:GROUP_SIZE] == 3'h7);
	endproperty
	a_group_split: assert property (p_group_split) // R08
		else $error("groups not independent");

	c_fault: cover property (@(posedge aclk) disable iff (!aresetn)
		fault_sync != 6'h00 ##1 state.fault != 6'h00);
	c_reset: cover property (@(posedge aclk) disable iff (!aresetn)
		cmd_write && cmd.reset_req && state.fault != 6'h00);
	c_group: cover property (@(posedge aclk) disable iff (!aresetn)
		output_enable == 6'h38);
endmodule // gate_supervisor

// *** rtl/gate_supervisor_regs.svh ***
// Register offsets, field positions and reset values of the gate supervisor.
`ifndef GATE_SUPERVISOR_REGS_SVH
`define GATE_SUPERVISOR_REGS_SVH
`define CHANNEL_COUNT 6
`define REG_COMMAND 4'h0
`define REG_STATUS 4'h4
`define REG_PACKETS 4'h8
`define CMD_ENABLE_LSB 0
`define CMD_RESET_BIT 8
`define STAT_FAULT_LSB 0
`define STAT_ENABLE_LSB 8
`define STAT_INDICATOR_BIT 16
`define ENABLE_RESET 6'h3F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/gate_supervisor_pkg.sv ***
// Types shared by the gate supervisor files.
package gate_supervisor_pkg;
	typedef logic [5:0] chan_t;
	typedef struct packed {
		logic reset_req;
		chan_t enable_req;
	} command_s;
	typedef struct packed {
		chan_t fault;
		chan_t enable;
	} status_s;
endpackage

// *** rtl/pwm_gate_mask.sv ***
// Gates the PWM drive of the six channels by their output enables.
`timescale 1ns/1ps
module pwm_gate_mask
	import gate_supervisor_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire chan_t enable,
	input wire logic [5:0] pwm_high_in,
	input wire logic [5:0] pwm_low_in,
	output logic [5:0] gate_high,
	output logic [5:0] gate_low
);
	logic [5:0] next_gate_high;
	logic [5:0] next_gate_low;

	always_comb begin
		next_gate_high = pwm_high_in & enable; // R07
		next_gate_low = pwm_low_in & enable; // R07
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_high <= 6'h00;
			gate_low <= 6'h00;
		end else begin
			gate_high <= next_gate_high;
			gate_low <= next_gate_low;
		end
	end

	property p_off_low;
		@(posedge aclk) disable iff (!aresetn)
		(enable == 6'h00) |=> (gate_high == 6'h00 && gate_low == 6'h00);
	endproperty
	a_off_low: assert property (p_off_low) // R07
		else $error("disabled channel drives gate");
endmodule // pwm_gate_mask

// *** tb/host_model.sv ***
// Host model that sends command packets and polls status over AXI4-Lite.
`timescale 1ns/1ps
`include "gate_supervisor_regs.svh"
module host_model (
	input wire logic aclk,
	output logic [3:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [3:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// Released address and data lines show the inverse of the last value.
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit pa, pw, pb;
		@(posedge aclk);
		pa = 1;
		pw = 1;
		pb = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw || pb) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (pb && s_axi_bvalid) begin
				pb = 0;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit pa, pr;
		@(posedge aclk);
		pa = 1;
		pr = 1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (pa || pr) begin
			@(posedge aclk);
			if (pa && s_axi_arready) begin
				pa = 0;
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (pr && s_axi_rvalid) begin
				pr = 0;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask
	// The reset request rides in each packet sent with rs set; the next packet carries the rs of its own call.
	task automatic send(input logic [5:0] en, input logic rs,
		output logic [1:0] r);
		wr(`REG_COMMAND, {23'h0, rs, 2'h0, en}, r);
	endtask
	// Only the byte lanes set in s reach the register; all lanes after.
	task automatic wr_lanes(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		s_axi_wstrb <= s;
		wr(a, d, r);
		s_axi_wstrb <= 4'hF;
	endtask
endmodule // host_model

// *** tb/gate_supervisor_tb.sv ***
// Self-checking bench for the gate supervisor.
`timescale 1ns/1ps
`include "gate_supervisor_regs.svh"
module gate_supervisor_tb
	import gate_supervisor_pkg::*;
;
	logic aclk = 1'b0, aresetn, packet_indicator;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [5:0] driver_fault, pwm_high_in, pwm_low_in;
	logic [5:0] gate_high, gate_low, output_enable;
	logic [31:0] d;
	logic ind = 1'b0;
	int error_cnt = 0, checks = 0, cyc = 0, pk = 0;
	always #10 aclk = ~aclk;
	gate_supervisor dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .driver_fault,
		.pwm_high_in, .pwm_low_in, .gate_high, .gate_low, .output_enable,
		.packet_indicator);
	host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmd(input chan_t en, input logic rs);
		host.send(en, rs, r);
		chk(r, `RESP_OKAY);
		ind = ~ind;
		pk++;
	endtask
	task automatic st(input chan_t f, input chan_t e);
		host.rd(`REG_STATUS, d, r);
		chk(d, {15'h0, ind, 2'h0, e, 2'h0, f});
		chk(output_enable, e);
		chk(packet_indicator, ind);
	endtask
	task automatic gates(input chan_t e);
		repeat (2) @(posedge aclk);
		#1;
		chk(gate_high, e);
		chk(gate_low, e & 6'h15);
		@(posedge aclk);
	endtask
	task automatic lanes(input logic [31:0] v, input logic [3:0] s,
		input chan_t e);
		host.wr_lanes(`REG_COMMAND, v, s, r);
		chk(r, `RESP_OKAY);
		ind = ~ind;
		pk++;
		st(6'h00, e);
	endtask
	task automatic t_groups;
		chan_t tab [3] = '{6'h38, 6'h07, 6'h3F};
		st(6'h00, `ENABLE_RESET);
		foreach (tab[i]) begin
			cmd(tab[i], 1'b0);
			st(6'h00, tab[i]);
			gates(tab[i]);
		end
		$display("test groups done");
	endtask
	task automatic t_fault;
		driver_fault <= 6'h04;
		repeat (6) @(posedge aclk);
		driver_fault <= 6'h00;
		st(6'h04, 6'h00);
		gates(6'h00);
		cmd(6'h3F, 1'b0);
		st(6'h04, 6'h00);
		$display("test fault done");
	endtask
	task automatic t_clear;
		driver_fault <= 6'h20;
		repeat (6) @(posedge aclk);
		cmd(6'h00, 1'b1);
		st(6'h20, 6'h00);
		driver_fault <= 6'h00;
		repeat (6) @(posedge aclk);
		cmd(6'h00, 1'b1);
		st(6'h00, 6'h3F);
		gates(6'h3F);
		$display("test clear done");
	endtask
	task automatic t_bus;
		host.wr(4'hC, 32'h0000003F, r);
		chk(r, `RESP_SLVERR);
		host.rd(4'hC, d, r);
		chk(r, `RESP_SLVERR);
		chk(d, 32'h00000000);
		host.wr(`REG_STATUS, 32'h0000FFFF, r);
		chk(r, `RESP_OKAY);
		st(6'h00, 6'h3F);
		host.rd(`REG_COMMAND, d, r);
		chk(d, 32'h0000003F);
		lanes(32'h00000100, 4'h1, 6'h00);
		lanes(32'h0000003F, 4'h2, 6'h00);
		cmd(6'h3F, 1'b0);
		st(6'h00, 6'h3F);
		host.rd(`REG_PACKETS, d, r);
		chk(d, pk);
		$display("test bus done");
	endtask
	task automatic t_reset;
		driver_fault <= 6'h01;
		repeat (6) @(posedge aclk);
		driver_fault <= 6'h00;
		st(6'h01, 6'h00);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		ind = 1'b0;
		pk = 0;
		st(6'h00, `ENABLE_RESET);
		host.rd(`REG_PACKETS, d, r);
		chk(d, pk);
		$display("test reset done");
	endtask
	initial begin
		aresetn = 1'b0;
		driver_fault = 6'h00;
		pwm_high_in = 6'h3F;
		pwm_low_in = 6'h15;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_groups;
		t_fault;
		t_clear;
		t_bus;
		t_reset;
		tally_and_finish;
	end
endmodule // gate_supervisor_tb
